// ==== verilog/serial_eeprom_64x16_defines.svh ====
`ifndef SERIAL_EEPROM_64X16_DEFINES_SVH
`define SERIAL_EEPROM_64X16_DEFINES_SVH

// Array shape
`define SEE_WORDS        64
`define SEE_ADDR_W       6
`define SEE_DATA_W       16
`define SEE_WORD_ERASED  16'hffff

// Operation codes and sub-commands of op 00 (top two address bits)
`define SEE_OP_MISC      2'h0
`define SEE_OP_WRITE     2'h1
`define SEE_OP_READ      2'h2
`define SEE_OP_ERASE     2'h3
`define SEE_SUB_DISABLE  2'h0
`define SEE_SUB_ERASEALL 2'h2
`define SEE_SUB_ENABLE   2'h3

// Bit counts after the lead bit
`define SEE_CNT_W        5
`define SEE_HDR_LAST     5'h08
`define SEE_DATA_LAST    5'h10

// Self-timed programming cycle
`define SEE_PROG_TIME_MS 10
`define SEE_CLK_PERIOD_NS 10
`define SEE_PROG_CYCLES  ((`SEE_PROG_TIME_MS * 1000000) / `SEE_CLK_PERIOD_NS)
`define SEE_TIMER_W      20

`endif

// ==== verilog/serial_eeprom_64x16_pkg.sv ====
package serial_eeprom_64x16_pkg;

	// One instruction as captured at the link
	typedef struct packed {
		logic [1:0]  op;
		logic [5:0]  addr;
		logic [15:0] data;
	} instr_t;

	// Link-side shift states
	typedef enum logic [3:0] {
		LNK_IDLE = 4'b0001,
		LNK_HDR  = 4'b0010,
		LNK_DATA = 4'b0100,
		LNK_READ = 4'b1000
	} link_state_t;

endpackage

// ==== verilog/serial_eeprom_64x16.sv ====
`timescale 1ns/10ps
`include "serial_eeprom_64x16_defines.svh"
// Functional notes
// [RULE1] Array of 64 words, 16 bits each
// [RULE2] Nine bits: lead one, opcode, address
// [RULE3] First one is lead, next eight decoded
// [RULE4] Opcodes: 10 read, 01 write, 11 erase
// [RULE5] Op 00: enable, disable, erase every word
// [RULE6] Read: zero dummy bit, then 16 bits
// [RULE7] Output changes only while clock high
// [RULE8] Output driven only for data or status
// [RULE9] Programming disabled at start; enable first
// [RULE10] Reads work regardless of programming enable
// [RULE11] Erase starts at select fall, sets ones
// [RULE12] Write takes 16 bits, starts at fall
// [RULE13] Status: low while busy, high when done
// [RULE14] Host erases before write; write only clears
// [RULE15] Erase every word sets all ones
// [RULE16] Host keeps select low one microsecond
// [RULE17] Programming and status need no link clock
// [RULE18] Select low means standby, nothing accepted
// [RULE19] Sample input on rising clock, skip zeros
// [RULE20] Programming lasts set time, refuses instructions
module serial_eeprom_64x16 #(
	parameter int unsigned PROG_CYCLES = `SEE_PROG_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ser_clk,
	input  wire logic i_cs,
	input  wire logic i_ser_in,
	output logic      o_ser_out,
	output logic      o_ser_oe
);

	// Link side notes:
	// - Everything here runs on the host's serial clock, which stops
	//   between frames, so nothing here may wait for time to pass.
	// - Select low clears the sequencer at once; a frame cut short
	//   leaves no trace, since only complete instructions toggle.
	// - The data input needs no synchroniser: the host changes it
	//   while the clock is low, well away from the sampling edge.
	// - Reset arrives through two flops of this clock, so the host
	//   must give a few clock edges with select low during reset.
	serial_eeprom_64x16_pkg::link_state_t lnk_st_r;
	logic [`SEE_CNT_W-1:0]   cnt_r;
	logic [7:0]              hdr_r;
	logic [`SEE_DATA_W-1:0]  wdat_r;
	logic [`SEE_DATA_W-1:0]  rd_shift_r;
	logic                    rd_bit_r;
	logic                    rd_oe_r;
	logic                    done_tgl_r;
	logic                    bz_s1_r;
	logic                    bz_s2_r;
	logic                    busy_r;             // System side flop, read here through bz_s1_r
	logic                    lnk_rst_n_s1_r;
	logic                    lnk_rst_n_s2_r;
	logic [`SEE_DATA_W-1:0]  mem_r [`SEE_WORDS];

	wire logic [7:0]             hdr_nxt  = {hdr_r[6:0], i_ser_in};
	wire logic [`SEE_DATA_W-1:0] wdat_nxt = {wdat_r[`SEE_DATA_W-2:0], i_ser_in};
	wire logic [1:0]             hdr_op   = hdr_nxt[7:6];
	wire logic                   hdr_end  = (lnk_st_r == serial_eeprom_64x16_pkg::LNK_HDR) &&
	                                        (cnt_r == `SEE_HDR_LAST - 5'h01);
	wire logic                   data_end = (lnk_st_r == serial_eeprom_64x16_pkg::LNK_DATA) &&
	                                        (cnt_r == `SEE_DATA_LAST - 5'h01);
	wire logic                   lnk_busy = bz_s2_r;

	// Frame outcomes at the last header or data bit
	wire logic                   lnk_rd_go   = hdr_end && !lnk_busy && hdr_op == `SEE_OP_READ;
	wire logic                   lnk_cmd_end = i_cs && !lnk_busy && ((hdr_end && hdr_op != `SEE_OP_READ &&
	                                           hdr_op != `SEE_OP_WRITE) || data_end);

	// Busy level into the link domain; fresh by the eighth header bit
	always_ff @(posedge i_ser_clk) begin
		bz_s1_r <= busy_r;
		bz_s2_r <= bz_s1_r;
	end

	// Reset into the link domain; needs serial clock edges to land
	always_ff @(posedge i_ser_clk) begin
		lnk_rst_n_s1_r <= i_rst_n;
		lnk_rst_n_s2_r <= lnk_rst_n_s1_r;
	end

	// Shift registers, no reset: only consumed after a full capture
	always_ff @(posedge i_ser_clk) begin
		if (i_cs && lnk_st_r == serial_eeprom_64x16_pkg::LNK_HDR) begin
			hdr_r <= hdr_nxt;                          // [RULE2]
		end
		if (i_cs && lnk_st_r == serial_eeprom_64x16_pkg::LNK_DATA) begin
			wdat_r <= wdat_nxt;                        // [RULE12]
		end
	end

	// Frame sequencer; select low clears it at once (standby)
	always_ff @(posedge i_ser_clk or negedge i_cs) begin
		if (!i_cs) begin
			lnk_st_r <= serial_eeprom_64x16_pkg::LNK_IDLE; // [RULE18]
			cnt_r    <= 5'h00;
			rd_oe_r  <= 1'b0;                          // [RULE8]
		end else begin
			unique case (lnk_st_r)
				serial_eeprom_64x16_pkg::LNK_IDLE: begin
					if (i_ser_in) begin
						lnk_st_r <= serial_eeprom_64x16_pkg::LNK_HDR; // [RULE19] [RULE3]
					end
					cnt_r <= 5'h00;
				end
				serial_eeprom_64x16_pkg::LNK_HDR: begin
					cnt_r <= cnt_r + 5'h01;
					if (hdr_end) begin
						cnt_r <= 5'h00;
						if (lnk_busy) begin
							lnk_st_r <= serial_eeprom_64x16_pkg::LNK_READ; // [RULE20]
						end else if (hdr_op == `SEE_OP_READ) begin
							lnk_st_r <= serial_eeprom_64x16_pkg::LNK_READ; // [RULE10]
							rd_oe_r  <= 1'b1;          // [RULE6]
						end else if (hdr_op == `SEE_OP_WRITE) begin
							lnk_st_r <= serial_eeprom_64x16_pkg::LNK_DATA;
						end else begin
							lnk_st_r <= serial_eeprom_64x16_pkg::LNK_READ;
						end
					end
				end
				serial_eeprom_64x16_pkg::LNK_DATA: begin
					cnt_r <= cnt_r + 5'h01;
					if (data_end) begin
						lnk_st_r <= serial_eeprom_64x16_pkg::LNK_READ;
					end
				end
				serial_eeprom_64x16_pkg::LNK_READ: begin
					cnt_r <= cnt_r;                    // Parked until select falls
				end
				default: begin
					lnk_st_r <= serial_eeprom_64x16_pkg::LNK_IDLE; // Illegal code: back to idle
				end
			endcase
		end
	end

	// Read shifter: updates on the rising edge, so data is stable while clock low
	always_ff @(posedge i_ser_clk) begin
		if (lnk_rd_go) begin
			rd_shift_r <= mem_r[hdr_nxt[5:0]];         // [RULE6]
			rd_bit_r   <= 1'b0;                        // [RULE6] [RULE7]
		end else if (rd_oe_r) begin
			rd_bit_r   <= rd_shift_r[`SEE_DATA_W-1];   // [RULE7]
			rd_shift_r <= {rd_shift_r[`SEE_DATA_W-2:0], 1'b0};
		end
	end

	// Toggle marks a complete non-read instruction; fields then stay still
	always_ff @(posedge i_ser_clk) begin
		if (!lnk_rst_n_s2_r && !i_cs) begin
			done_tgl_r <= 1'b0;
		end else if (lnk_cmd_end) begin
			done_tgl_r <= ~done_tgl_r;                 // [RULE3]
		end
	end

	// System side notes:
	// - A finished instruction is announced by a toggle; its fields
	//   were written on the edge that moved the toggle or earlier and stay still until the
	//   next frame, which needs select low first, so they are safe to
	//   copy once the synchronised toggle edge is seen.
	// - Select passes two flops before use; the third only marks its
	//   falling edge, which starts the stored instruction.
	// - The busy level goes back to the link through two flops of the
	//   serial clock; a full header takes nine edges, so the value
	//   seen at the last address bit is fresh.
	// - The array is read straight from the link side. It only
	//   changes when a cycle ends, and reads are refused while busy,
	//   so a read never meets a moving word.
	// - The timer keeps running with the link clock stopped.
	logic                    cs_s1_r;
	logic                    cs_s2_r;
	logic                    cs_d_r;
	logic                    tg_s1_r;
	logic                    tg_s2_r;
	logic                    tg_d_r;
	logic                    pend_vld_r;
	serial_eeprom_64x16_pkg::instr_t pend_r;
	serial_eeprom_64x16_pkg::instr_t cur_r;
	logic                    prog_en_r;
	logic [`SEE_TIMER_W-1:0] timer_r;
	logic                    stat_arm_r;

	serial_eeprom_64x16_pkg::instr_t lnk_instr;
	serial_eeprom_64x16_pkg::instr_t pend_cur;
	assign lnk_instr = '{op: hdr_r[7:6], addr: hdr_r[5:0], data: wdat_r};

	// Edge detection on synchronised select and done toggle
	wire logic cs_fall  = cs_d_r & ~cs_s2_r;
	wire logic tg_edge  = tg_d_r ^ tg_s2_r;
	wire logic pend_hit = pend_vld_r | (tg_edge & ~busy_r);
	assign pend_cur = tg_edge ? lnk_instr : pend_r;

	// Command decode of the instruction about to run
	wire logic [1:0] sub      = pend_cur.addr[5:4];
	wire logic       is_misc  = pend_cur.op == `SEE_OP_MISC;
	wire logic       is_en    = is_misc && sub == `SEE_SUB_ENABLE;   // [RULE5]
	wire logic       is_dis   = is_misc && sub == `SEE_SUB_DISABLE;  // [RULE5]
	wire logic       is_erase_every_word_cmd  = is_misc && sub == `SEE_SUB_ERASEALL; // [RULE5]
	wire logic       is_prog  = pend_cur.op == `SEE_OP_WRITE || pend_cur.op == `SEE_OP_ERASE || is_erase_every_word_cmd;
	wire logic       exec     = cs_fall & pend_hit & ~busy_r;
	wire logic       start    = exec & is_prog & prog_en_r;          // [RULE9] [RULE11] [RULE12]
	wire logic       finish   = busy_r && timer_r == '0;
	wire logic       cur_erase_every_word_cmd = cur_r.op == `SEE_OP_MISC;

	// Select and toggle synchronisers
	always_ff @(posedge i_clk) begin
		cs_s1_r <= i_cs;
		cs_s2_r <= cs_s1_r;
		cs_d_r  <= cs_s2_r;
		tg_s1_r <= done_tgl_r;
		tg_s2_r <= tg_s1_r;
		tg_d_r  <= tg_s2_r;
	end

	// Pending instruction; a capture in the clearing cycle wins
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pend_vld_r <= 1'b0;
		end else if (tg_edge && !busy_r) begin
			pend_vld_r <= ~cs_fall;
		end else if (cs_fall) begin
			pend_vld_r <= 1'b0;
		end
		if (tg_edge) begin
			pend_r <= lnk_instr;
		end
	end

	// Programming enable latch, off from reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prog_en_r <= 1'b0;                         // [RULE9]
		end else if (exec && is_en) begin
			prog_en_r <= 1'b1;                         // [RULE9]
		end else if (exec && is_dis) begin
			prog_en_r <= 1'b0;                         // [RULE9]
		end
	end

	// Self-timed cycle runs on i_clk, so the link clock may stop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			busy_r  <= 1'b0;
			timer_r <= '0;
		end else if (start) begin
			busy_r  <= 1'b1;                           // [RULE17] [RULE20]
			timer_r <= `SEE_TIMER_W'(PROG_CYCLES - 1);  // [RULE20]
		end else if (finish) begin
			busy_r  <= 1'b0;
		end else if (busy_r) begin
			timer_r <= timer_r - `SEE_TIMER_W'(1);
		end
		if (start) begin
			cur_r <= pend_cur;
		end
	end

	// Status shown after a cycle starts, until select falls once ready
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			stat_arm_r <= 1'b0;
		end else if (start) begin
			stat_arm_r <= 1'b1;                        // [RULE13]
		end else if (cs_fall && !busy_r) begin
			stat_arm_r <= 1'b0;
		end
	end

	// Array words; contents land only when the cycle ends
	genvar gi;
	generate
		for (gi = 0; gi < `SEE_WORDS; gi++) begin : g_word
			wire logic hit = finish && (cur_erase_every_word_cmd || cur_r.addr == `SEE_ADDR_W'(gi)); // [RULE1]
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					mem_r[gi] <= `SEE_WORD_ERASED;
				end else if (hit && cur_r.op == `SEE_OP_WRITE) begin
					mem_r[gi] <= mem_r[gi] & cur_r.data;   // [RULE12] [RULE14]
				end else if (hit) begin
					mem_r[gi] <= `SEE_WORD_ERASED;         // [RULE11] [RULE15]
				end
			end
		end
	endgenerate

	// Output pin: read data from the link, else busy status
	wire logic stat_oe  = cs_s2_r & stat_arm_r;
	wire logic stat_bit = ~busy_r;                             // Low while busy, high once done
	assign o_ser_out = rd_oe_r ? rd_bit_r : stat_bit;          // [RULE13]
	assign o_ser_oe  = rd_oe_r | stat_oe;                      // [RULE8]

endmodule

// ==== dv/serial_eeprom_64x16_chk.sv ====
`timescale 1ns/10ps
// Pin checks of the serial memory, top ports only
module serial_eeprom_64x16_chk #(
	parameter int unsigned PROG_CYCLES = 50
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ser_clk,
	input wire logic i_cs,
	input wire logic i_ser_in,
	input wire logic o_ser_out,
	input wire logic o_ser_oe
);
	logic [31:0] low_cnt_r;

	// Busy status run length; a stuck timer shows here
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !(i_cs && o_ser_oe && !o_ser_out)) begin
			low_cnt_r <= '0;
		end else begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end
	end

	// Select held low long enough for the synced path
	sequence quiet_s;
		!i_cs [*6];
	endsequence

	standby_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) quiet_s |-> !o_ser_oe)
		else $error("pin driven in standby");
	oe_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_ser_oe) |-> i_cs)
		else $error("pin driven without select");
	oe_fall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_ser_oe) |-> !i_cs)
		else $error("pin released under select");
	cs_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) $fell(i_cs) |-> ##[1:5] !o_ser_oe)
		else $error("pin not released");
	dummy_bit_a: assert property (@(posedge i_ser_clk) disable iff (!i_cs) $rose(o_ser_oe) |-> !o_ser_out)
		else $error("first output bit not zero");
	change_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_ser_oe && $past(o_ser_oe) && !i_ser_clk && !$past(i_ser_clk) |-> $stable(o_ser_out))
		else $error("output moved while clock low");
	ready_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(o_ser_out) && $past(o_ser_oe) && o_ser_oe && i_ser_clk && $past(i_ser_clk) |-> o_ser_out)
		else $error("ready fell back");
	busy_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) low_cnt_r <= PROG_CYCLES)
		else $error("busy too long");
endmodule

bind serial_eeprom_64x16 serial_eeprom_64x16_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_ser_clk(i_ser_clk), .i_cs(i_cs), .i_ser_in(i_ser_in), .o_ser_out(o_ser_out),
	.o_ser_oe(o_ser_oe));

// ==== dv/serial_host.sv ====
`timescale 1ns/10ps
// Host model; link clock rests high outside frames
module serial_host (
	output logic o_ser_clk,
	output logic o_cs,
	output logic o_ser_in,
	input  wire  i_dout
);
	initial begin
		o_ser_clk = 1'b1;
		o_cs      = 1'b0;
		o_ser_in  = 1'b0;
	end

	// Shift k low bits of v, MSB first, data set while clock low
	task send(input logic [24:0] v, input int k, input logic sel);
		o_cs = sel;
		for (int b = k - 1; b >= 0; b--) begin
			o_ser_clk = 1'b0;
			o_ser_in  = v[b];
			#80 o_ser_clk = 1'b1;
			#80;
		end
	endtask

	// Dummy plus 16 bits, each taken before the next rise
	task get(output logic [16:0] q);
		for (int b = 0; b < 17; b++) begin
			o_ser_clk = 1'b0;
			#80 q = {q[15:0], i_dout};
			o_ser_clk = 1'b1;
			#80;
		end
	endtask

	// Select low for the minimum gap between frames
	task stop();
		o_cs = 1'b0;
		#1000;
	endtask
endmodule

// ==== dv/serial_eeprom_64x16_tb_top.sv ====
`timescale 1ns/10ps
module serial_eeprom_64x16_tb_top;
	localparam int unsigned PROG = 600; // Short cycle keeps the run brief
	logic        i_clk       = 1'b0;
	logic        i_rst_n     = 1'b0;
	wire         ser_clk;
	wire         cs;
	wire         ser_in;
	wire         ser_out;
	wire         ser_oe;
	wire         dout        = ser_oe ? ser_out : 1'bz; // Released pin floats
	int          err_total   = 0;
	int          checks_done = 0;
	int          n;
	logic [16:0] q;

	always #5 i_clk = ~i_clk;

	serial_eeprom_64x16 #(.PROG_CYCLES(PROG)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ser_clk(ser_clk),
		.i_cs(cs), .i_ser_in(ser_in), .o_ser_out(ser_out), .o_ser_oe(ser_oe));
	serial_host u_host (.o_ser_clk(ser_clk), .o_cs(cs), .o_ser_in(ser_in), .i_dout(dout));

	task chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task test_done();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Two zeros before the lead bit must be skipped
	task rd(input logic [5:0] a, input logic [15:0] d);
		u_host.send({14'h0, 5'b00110, a}, 11, 1'b1);
		u_host.get(q);
		u_host.stop();
		chk("read", {1'b0, d}, q);
	endtask

	// Program frame, then poll status with the link clock still
	task pw(input logic [24:0] v, input int k, input logic shown);
		u_host.send(v, k, 1'b1);
		u_host.stop();
		u_host.send(25'h0, 0, 1'b1);
		#1000 chk("busy", {16'h0, shown ? 1'b0 : 1'bz}, {16'h0, dout});
		for (n = 0; shown && n < 1000 && dout !== 1'b1; n++) #10;
		if (shown) chk("ready", 17'h1, 17'(n > 380 && n < 430));
		u_host.stop();
	endtask

	task t_off();
		pw({1'b1, 2'b01, 6'h05, 16'h0000}, 25, 1'b0);
		rd(6'h05, 16'hffff);
		$display("t_off done");
	endtask

	// Second write without erase only clears bits
	task t_write();
		u_host.send(25'h130, 9, 1'b1);
		u_host.stop();
		pw({1'b1, 2'b01, 6'h2a, 16'h5a3c}, 25, 1'b1);
		rd(6'h2a, 16'h5a3c);
		pw({1'b1, 2'b01, 6'h2a, 16'h0ff0}, 25, 1'b1);
		rd(6'h2a, 16'h0a30);
		pw({1'b1, 2'b01, 6'h3f, 16'h0000}, 25, 1'b1);
		$display("t_write done");
	endtask

	// Write sent while erasing every word must be dropped
	task t_erase();
		pw({16'h0, 1'b1, 2'b11, 6'h2a}, 9, 1'b1);
		rd(6'h2a, 16'hffff);
		rd(6'h3f, 16'h0000);
		u_host.send(25'h120, 9, 1'b1);
		u_host.stop();
		u_host.send({1'b1, 2'b01, 6'h3f, 16'h1234}, 25, 1'b1);
		u_host.stop();
		#3000 rd(6'h3f, 16'hffff);
		u_host.send(25'h100, 9, 1'b1);
		u_host.stop();
		pw({1'b1, 2'b01, 6'h3f, 16'h0000}, 25, 1'b0);
		rd(6'h3f, 16'hffff);
		$display("t_erase done");
	endtask

	// Watchdog: several times the expected run
	initial begin
		#400000;
		err_total++;
		$display("BAD watchdog exp finish got timeout");
		test_done();
	end

	// Link edges with select low during reset clear the link side
	initial begin
		repeat (2) @(negedge i_clk);
		u_host.send(25'h0, 4, 1'b0);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_clk);
		t_off();
		t_write();
		t_erase();
		test_done();
	end
endmodule
